// ### rtl/pse_port_regs.svh
/*
 * register offsets, field positions, reset values and timing figures
 * of the quad port command block.
 * assumes a 40 MHz system clock; included by its bare name.
 */
`ifndef PSE_PORT_REGS_SVH
`define PSE_PORT_REGS_SVH

// ============================================================
// register offsets
`define PSE_OFS_GLOBAL 8'h17
`define PSE_OFS_PROBE 8'h18
`define PSE_OFS_POWER 8'h19

// ============================================================
// global option fields and reset value
`define PSE_GLB_RESET 8'h80
`define PSE_GLB_ALERT_OFF 7
`define PSE_GLB_MULTIBIT 4
`define PSE_GLB_CLASS_CHG 3
`define PSE_GLB_DETECT_CHG 2
`define PSE_GLB_MIDSPAN 1
`define PSE_GLB_WMASK 8'h9e

// ============================================================
// command field positions: upper nibble class/off, lower detect/on
`define PSE_CMD_HI 4
`define PSE_CMD_LO 0

// ============================================================
// timing and budget figures
`define PSE_CLK_KHZ 40000
`define PSE_INRUSH_MS 60
`define PSE_BUDGET_BASE 8'h10
`define PSE_BUDGET_STEP 8'h20

`endif

// ### rtl/pse_pkg.sv
/*
 * types shared by the quad port command block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package pse_pkg;
	typedef enum logic [1:0]
	{
		PSE_MODE_SHUTDOWN,
		PSE_MODE_MANUAL,
		PSE_MODE_HOST_ASSISTED,
		PSE_MODE_AUTO
	} pse_mode_type;

	typedef enum logic [2:0]
	{
		SEQ_IDLE,
		SEQ_WAIT_PROBE,
		SEQ_DETECT,
		SEQ_CLASSIFY,
		SEQ_INRUSH,
		SEQ_GOOD
	} pse_seq_state_type;
endpackage : pse_pkg

// ### rtl/pse_port_seq.sv
/*
 * power-up sequencer of one port: probes, fet on, inrush, power good.
 * assumes probe engine and analog monitors are synchronous to clk_sys.
 */
`timescale 1ns/10ps
`include "pse_port_regs.svh"

module pse_port_seq #(
	parameter int unsigned INRUSH_CYCLES = `PSE_INRUSH_MS * `PSE_CLK_KHZ
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic portClear,
	input wire logic powerOn,
	input wire logic skipProbe,
	input wire logic probeBusy,
	input wire logic detectValid,
	input wire logic classValid,
	input wire logic probeFault,
	input wire logic drainLow,
	input wire logic removePower,
	output logic detectReq,
	output logic classReq,
	output logic fetOn,
	output logic powerGood,
	output logic preFaultEvt,
	output logic inrushFaultEvt,
	output logic loadBudget
);
	pse_pkg::pse_seq_state_type state_reg;
	logic [31:0] inrushCnt_reg;

	// ============================================================
	// sequence
	always_ff @(posedge clk_sys)
	begin
		detectReq <= 1'b0;
		classReq <= 1'b0;
		preFaultEvt <= 1'b0;
		inrushFaultEvt <= 1'b0;
		loadBudget <= 1'b0;
		if (!rst_b || portClear)
		begin
			state_reg <= pse_pkg::SEQ_IDLE;
			fetOn <= 1'b0;
			powerGood <= 1'b0;
			inrushCnt_reg <= 32'h0;
		end
		else
		begin
			case (state_reg)
				pse_pkg::SEQ_IDLE:
					if (powerOn && skipProbe)
					begin
						fetOn <= 1'b1;
						loadBudget <= 1'b1;
						inrushCnt_reg <= 32'h0;
						state_reg <= pse_pkg::SEQ_INRUSH;
					end
					else if (powerOn)
						state_reg <= pse_pkg::SEQ_WAIT_PROBE;
				pse_pkg::SEQ_WAIT_PROBE:
					// running probes finish before the fresh ones
					if (!probeBusy)
					begin
						detectReq <= 1'b1;
						state_reg <= pse_pkg::SEQ_DETECT;
					end
				pse_pkg::SEQ_DETECT:
					if (probeFault)
					begin
						preFaultEvt <= 1'b1;
						state_reg <= pse_pkg::SEQ_IDLE;
					end
					else if (detectValid)
					begin
						classReq <= 1'b1;
						state_reg <= pse_pkg::SEQ_CLASSIFY;
					end
				pse_pkg::SEQ_CLASSIFY:
					if (probeFault)
					begin
						preFaultEvt <= 1'b1;
						state_reg <= pse_pkg::SEQ_IDLE;
					end
					else if (classValid)
					begin
						fetOn <= 1'b1;
						loadBudget <= 1'b1;
						inrushCnt_reg <= 32'h0;
						state_reg <= pse_pkg::SEQ_INRUSH;
					end
				pse_pkg::SEQ_INRUSH:
					if (removePower)
					begin
						fetOn <= 1'b0;
						state_reg <= pse_pkg::SEQ_IDLE;
					end
					else if (inrushCnt_reg + 32'h1 < INRUSH_CYCLES)
						inrushCnt_reg <= inrushCnt_reg + 32'h1;
					else if (drainLow)
					begin
						powerGood <= 1'b1;
						state_reg <= pse_pkg::SEQ_GOOD;
					end
					else
					begin
						fetOn <= 1'b0;
						inrushFaultEvt <= 1'b1;
						state_reg <= pse_pkg::SEQ_IDLE;
					end
				pse_pkg::SEQ_GOOD:
					if (removePower)
					begin
						fetOn <= 1'b0;
						powerGood <= 1'b0;
						state_reg <= pse_pkg::SEQ_IDLE;
					end
				default:
					state_reg <= pse_pkg::SEQ_IDLE;
			endcase
		end
	end
endmodule : pse_port_seq

// ### rtl/pse_port_cmd.sv
/*
 * global options and the probe and power command registers of a four
 * port power sourcing controller, with per-port status and budgets.
 * assumes a register port already decoded from the two-wire interface,
 * a probe engine and analog monitors, all synchronous to clk_sys.
 */
// What this block does
// - global bit 7 gates alert pin drive, 1 disables; resets to 0x80
// - global bit 4 picks single-bit or multi-bit port priority
// - global bit 3: class-done on every update, or only on change
// - global bit 2: detect-done on every update, or only on change
// - global bit 1 picks endspan (0) or midspan (1) placement
// - probe command: class bits 7..4, detect bits 3..0, port 4 high
// - pair 00 nothing, 01 detect, 10 invalid, 11 detect and class
// - in host-assisted and auto modes probe bits go to the probe-enable register
// - power command bits 7..4 set to 1 power the port off
// - power-off, emergency, reinit or shutdown reset port state
// - power-on lets probes finish, then detects and classifies anew
// - faults before fet on give a pre-power fault event
// - fet on sets supply-on, then an inrush interval runs
// - drain not below 2 V after inrush: disconnect, inrush fault
// - budget loaded from granted tier; overruns give over-budget events
// - autoclass power updates budget when enabled and supported
// - host may overwrite budget later; device polices that value
// - manual with both probe enables 0 powers at once, host budget
// - keep-power bit keeps power on overruns but still reports
`timescale 1ns/10ps
`include "pse_port_regs.svh"

module pse_port_cmd #(
	parameter int unsigned PORTS = 4,
	parameter int unsigned INRUSH_CYCLES = `PSE_INRUSH_MS * `PSE_CLK_KHZ
) (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic alertRequest,
	input wire logic alert_pin_n_in,
	output logic alert_pin_n_out,
	output logic alert_pin_n_oe,
	output logic multiBitPriority,
	output logic midspan,
	input wire logic [7:0] portMode,
	input wire logic probeEnableLoad,
	input wire logic [7:0] probeEnableIn,
	output logic [7:0] probeEnable,
	output logic [3:0] probeDetectReq,
	output logic [3:0] probeClassReq,
	input wire logic [3:0] probeBusy,
	input wire logic [3:0] detectValid,
	input wire logic [15:0] detectResult,
	input wire logic [3:0] classValid,
	input wire logic [15:0] classResult,
	input wire logic [3:0] probeFault,
	output logic [15:0] detectStatus,
	output logic [15:0] classStatus,
	output logic [3:0] detectDoneEvt,
	output logic [3:0] classDoneEvt,
	input wire logic emergency_off_evt,
	input wire logic [3:0] portReinit,
	output logic [3:0] portClear,
	input wire logic [3:0] drainLow,
	output logic [3:0] fetOn,
	output logic [3:0] supplyOn,
	output logic [3:0] powerGood,
	output logic [3:0] preFaultEvt,
	output logic [3:0] inrushFaultEvt,
	input wire logic [15:0] granted_tier,
	input wire logic [31:0] host_budget,
	input wire logic [3:0] autoAutoclass,
	input wire logic [3:0] autoclassCapable,
	input wire logic [3:0] autoclassValid,
	input wire logic [31:0] autoclassPower,
	input wire logic [3:0] budgetWrEn,
	input wire logic [31:0] budgetWrData,
	output logic [31:0] budget_limit,
	input wire logic [31:0] measuredPower,
	input wire logic [3:0] keep_power_on_overbudget,
	input wire logic [3:0] current_limit_evt,
	input wire logic [3:0] disconnectEvt,
	output logic [3:0] overbudget_evt
);
	logic [7:0] global_reg;
	logic [3:0] portOnCmd;
	logic [3:0] port_off_cmd;
	logic [3:0] startPower;
	logic [3:0] skipProbe;
	logic [3:0] seqDetectReq;
	logic [3:0] seqClassReq;
	logic [3:0] cmdDetectReq;
	logic [3:0] cmdClassReq;
	logic [3:0] loadBudget;
	logic [3:0] removePower;
	logic [3:0] overRun;
	logic [3:0] overRun_reg;
	logic wrGlobal;
	logic wrProbe;
	logic wrPower;

	// ============================================================
	// helpers
	function automatic pse_pkg::pse_mode_type modeOf(
		input logic [7:0] modes,
		input int p
	);
		modeOf = pse_pkg::pse_mode_type'(modes[2*p +: 2]);
	endfunction : modeOf

	// budget per granted tier; a linear scale keeps the table small
	function automatic logic [7:0] tierBudget(input logic [3:0] tier);
		logic [7:0] prod;
		prod = 8'(tier * `PSE_BUDGET_STEP);
		tierBudget = prod + `PSE_BUDGET_BASE;
	endfunction : tierBudget

	// ============================================================
	// register port decode
	assign wrGlobal = regWrEn && regAddr == `PSE_OFS_GLOBAL;
	assign wrProbe = regWrEn && regAddr == `PSE_OFS_PROBE;
	assign wrPower = regWrEn && regAddr == `PSE_OFS_POWER;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			global_reg <= `PSE_GLB_RESET;
		else if (wrGlobal)
			global_reg <= regWrData & `PSE_GLB_WMASK;
	end

	// command registers are write only and read back as zero
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			regRdData <= 8'h00;
		else if (regRdEn && regAddr == `PSE_OFS_GLOBAL)
			regRdData <= global_reg;
		else if (regRdEn)
			regRdData <= 8'h00;
	end

	// ============================================================
	// global options
	// open drain: the pin is only ever pulled low, never driven high
	assign alert_pin_n_out = 1'b0;
	assign alert_pin_n_oe = alertRequest &&
		!global_reg[`PSE_GLB_ALERT_OFF];
	assign multiBitPriority = global_reg[`PSE_GLB_MULTIBIT];
	assign midspan = global_reg[`PSE_GLB_MIDSPAN];

	// ============================================================
	// probe command
	always_comb
	begin
		cmdDetectReq = 4'h0;
		cmdClassReq = 4'h0;
		for (int p = 0; p < PORTS; p++)
		begin
			if (wrProbe && modeOf(portMode, p) == pse_pkg::PSE_MODE_MANUAL)
			begin
				// pair 10 is invalid and is dropped
				cmdDetectReq[p] = regWrData[`PSE_CMD_LO + p];
				cmdClassReq[p] = regWrData[`PSE_CMD_HI + p] &&
					regWrData[`PSE_CMD_LO + p];
			end
		end
	end

	assign probeDetectReq = cmdDetectReq | seqDetectReq;
	assign probeClassReq = cmdClassReq | seqClassReq;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			probeEnable <= 8'h00;
		else
		begin
			if (probeEnableLoad)
				probeEnable <= probeEnableIn;
			for (int p = 0; p < PORTS; p++)
			begin
				if (wrProbe &&
					(modeOf(portMode, p) == pse_pkg::PSE_MODE_HOST_ASSISTED ||
					modeOf(portMode, p) == pse_pkg::PSE_MODE_AUTO))
				begin
					probeEnable[`PSE_CMD_HI + p] <=
						regWrData[`PSE_CMD_HI + p];
					probeEnable[`PSE_CMD_LO + p] <=
						regWrData[`PSE_CMD_LO + p];
				end
			end
		end
	end

	// ============================================================
	// power command
	always_comb
	begin
		portOnCmd = 4'h0;
		port_off_cmd = 4'h0;
		skipProbe = 4'h0;
		portClear = 4'h0;
		for (int p = 0; p < PORTS; p++)
		begin
			if (wrPower)
			begin
				port_off_cmd[p] = regWrData[`PSE_CMD_HI + p];
				portOnCmd[p] = regWrData[`PSE_CMD_LO + p];
			end
			skipProbe[p] = modeOf(portMode, p) == pse_pkg::PSE_MODE_MANUAL &&
				!probeEnable[`PSE_CMD_HI + p] &&
				!probeEnable[`PSE_CMD_LO + p];
			portClear[p] = port_off_cmd[p] || emergency_off_evt ||
				portReinit[p] ||
				modeOf(portMode, p) == pse_pkg::PSE_MODE_SHUTDOWN;
		end
	end

	assign startPower = portOnCmd & ~port_off_cmd;

	// ============================================================
	// probe results and done events
	always_ff @(posedge clk_sys)
	begin
		detectDoneEvt <= 4'h0;
		classDoneEvt <= 4'h0;
		if (!rst_b)
		begin
			detectStatus <= 16'h0;
			classStatus <= 16'h0;
		end
		else
		begin
			for (int p = 0; p < PORTS; p++)
			begin
				// a result that lands with a clear is kept
				if (detectValid[p])
				begin
					detectStatus[4*p +: 4] <= detectResult[4*p +: 4];
					detectDoneEvt[p] <= !global_reg[`PSE_GLB_DETECT_CHG] ||
						detectResult[4*p +: 4] !=
						detectStatus[4*p +: 4];
				end
				else if (portClear[p])
					detectStatus[4*p +: 4] <= 4'h0;
				if (classValid[p])
				begin
					classStatus[4*p +: 4] <= classResult[4*p +: 4];
					classDoneEvt[p] <= !global_reg[`PSE_GLB_CLASS_CHG] ||
						classResult[4*p +: 4] !=
						classStatus[4*p +: 4];
				end
				else if (portClear[p])
					classStatus[4*p +: 4] <= 4'h0;
			end
		end
	end

	// ============================================================
	// budget and policing
	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			budget_limit <= 32'h0;
		else
		begin
			for (int p = 0; p < PORTS; p++)
			begin
				if (portClear[p])
					budget_limit[8*p +: 8] <= 8'h00;
				else if (loadBudget[p] && skipProbe[p])
					budget_limit[8*p +: 8] <= host_budget[8*p +: 8];
				else if (loadBudget[p])
					budget_limit[8*p +: 8] <=
						tierBudget(granted_tier[4*p +: 4]);
				else if (budgetWrEn[p])
					budget_limit[8*p +: 8] <= budgetWrData[8*p +: 8];
				else if (autoclassValid[p] && autoAutoclass[p] &&
					autoclassCapable[p])
					budget_limit[8*p +: 8] <= autoclassPower[8*p +: 8];
			end
		end
	end

	always_comb
	begin
		overRun = 4'h0;
		removePower = 4'h0;
		for (int p = 0; p < PORTS; p++)
		begin
			overRun[p] = powerGood[p] &&
				measuredPower[8*p +: 8] > budget_limit[8*p +: 8];
			removePower[p] = current_limit_evt[p] || disconnectEvt[p] ||
				(overRun[p] && !keep_power_on_overbudget[p]);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
		begin
			overRun_reg <= 4'h0;
			overbudget_evt <= 4'h0;
		end
		else
		begin
			overRun_reg <= overRun & ~portClear;
			overbudget_evt <= overRun & ~overRun_reg;
		end
	end

	// ============================================================
	// per-port sequencers
	assign supplyOn = fetOn;

	for (genvar g = 0; g < PORTS; g++)
	begin : gPort
		pse_port_seq #(
			.INRUSH_CYCLES(INRUSH_CYCLES)
		) uSeq (
			.clk_sys(clk_sys),
			.rst_b(rst_b),
			.portClear(portClear[g]),
			.powerOn(startPower[g]),
			.skipProbe(skipProbe[g]),
			.probeBusy(probeBusy[g]),
			.detectValid(detectValid[g]),
			.classValid(classValid[g]),
			.probeFault(probeFault[g]),
			.drainLow(drainLow[g]),
			.removePower(removePower[g]),
			.detectReq(seqDetectReq[g]),
			.classReq(seqClassReq[g]),
			.fetOn(fetOn[g]),
			.powerGood(powerGood[g]),
			.preFaultEvt(preFaultEvt[g]),
			.inrushFaultEvt(inrushFaultEvt[g]),
			.loadBudget(loadBudget[g])
		);
	end
endmodule : pse_port_cmd

// ### dv/pse_port_cmd_assertions.sv
/* checker of the port command block, bound to its top ports.
   assumes port 1 is the lowest slice of each per-port vector. */
`timescale 1ns/10ps
module pse_port_cmd_chk (
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic alertRequest,
	input wire logic alert_pin_n_oe,
	input wire logic multiBitPriority,
	input wire logic midspan,
	input wire logic [7:0] portMode,
	input wire logic [7:0] probeEnable,
	input wire logic [3:0] probeDetectReq,
	input wire logic [3:0] probeClassReq,
	input wire logic [3:0] portClear,
	input wire logic [3:0] drainLow,
	input wire logic [3:0] fetOn,
	input wire logic [3:0] supplyOn,
	input wire logic [3:0] powerGood,
	input wire logic [3:0] preFaultEvt,
	input wire logic [3:0] inrushFaultEvt
);
	// ====================
	// write decode
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	wire glbWr = regWrEn && regAddr == 8'h17;
	wire prbWr = regWrEn && regAddr == 8'h18;
	wire pwrWr = regWrEn && regAddr == 8'h19;
	// ====================
	// properties
	chk_alert_gate: assert property (glbWr |=>
		alert_pin_n_oe == (alertRequest && !$past(regWrData[7])))
		else $error("alert gate");
	chk_priority_pick: assert property (glbWr |=>
		multiBitPriority == $past(regWrData[4])) else $error("priority");
	chk_span_pick: assert property (glbWr |=>
		midspan == $past(regWrData[1])) else $error("span");
	chk_detect_req: assert property (prbWr && portMode[1:0] == 2'h1
		&& regWrData[0] |-> probeDetectReq[0]) else $error("detect req");
	chk_class_req: assert property (prbWr && portMode[7:6] == 2'h1
		&& regWrData[7] && regWrData[3] |-> probeClassReq[3])
		else $error("class req");
	chk_enable_copy: assert property (prbWr && portMode == 8'haa |=>
		probeEnable == $past(regWrData)) else $error("enable copy");
	chk_off_clear: assert property (pwrWr && regWrData[4] |->
		portClear[0] ##1 !fetOn[0]) else $error("power off");
	chk_supply_flag: assert property ($rose(supplyOn[0]) |->
		fetOn[0] && !powerGood[0] ##1 !powerGood[0])
		else $error("supply flag");
	chk_good_drain: assert property ($rose(powerGood[0]) |->
		$past(drainLow[0]) && fetOn[0]) else $error("power good");
	chk_inrush_drop: assert property (inrushFaultEvt[0] |->
		!fetOn[0] && !powerGood[0]) else $error("inrush drop");
	chk_prefault_off: assert property (preFaultEvt[0] |-> !fetOn[0])
		else $error("pre fault");
endmodule : pse_port_cmd_chk

bind pse_port_cmd pse_port_cmd_chk i_pse_port_cmd_chk (.*);

// ### dv/pse_host_model.sv
/* host model: one register access at a time on the decoded port.
   assumes a single calling process; lines are scrambled when idle. */
`timescale 1ns/10ps
module pse_host_model (
	input wire logic clk_sys,
	input wire logic [7:0] regRdData,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrEn,
	output logic regRdEn
);
	initial
	begin
		{regAddr, regWrData, regWrEn, regRdEn} = '0;
	end

	task wr(input logic [7:0] a, d);
		@(negedge clk_sys);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'h1;
		@(negedge clk_sys);
		regWrEn = 1'h0;
		regAddr = ~a;
		regWrData = ~d;
	endtask : wr

	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		regAddr = a;
		regRdEn = 1'h1;
		@(negedge clk_sys);
		regRdEn = 1'h0;
		regAddr = ~a;
		d = regRdData;
	endtask : rd
endmodule : pse_host_model

// ### dv/pse_port_command_control_bench.sv
/* bench of the port command block: host model on the register port,
   probe engine and monitors driven here, port 1 exercised. */
`timescale 1ns/10ps
module pse_port_command_control_bench;
	logic clk_sys, rst_b, regWrEn, regRdEn, alertRequest, alert_pin_n_in;
	logic probeEnableLoad, emergency_off_evt, alert_pin_n_out;
	logic alert_pin_n_oe, multiBitPriority, midspan;
	logic [7:0] regAddr, regWrData, regRdData, portMode, probeEnableIn;
	logic [7:0] probeEnable, rdv;
	logic [3:0] probeDetectReq, probeClassReq, probeBusy, detectValid;
	logic [3:0] classValid, probeFault, detectDoneEvt, classDoneEvt;
	logic [3:0] portReinit, portClear, drainLow, fetOn, supplyOn;
	logic [3:0] powerGood, preFaultEvt, inrushFaultEvt, autoAutoclass;
	logic [3:0] autoclassCapable, autoclassValid, budgetWrEn, seenDet;
	logic [3:0] keep_power_on_overbudget, current_limit_evt, seenCls;
	logic [3:0] disconnectEvt, overbudget_evt;
	logic [15:0] detectResult, classResult, detectStatus, classStatus;
	logic [15:0] granted_tier;
	logic [31:0] host_budget, autoclassPower, budgetWrData, budget_limit;
	logic [31:0] measuredPower;
	int n_fail, n_compared, nDet, nCls;

	// short inrush keeps the run brief
	pse_port_cmd #(.PORTS(4), .INRUSH_CYCLES(8)) i_pse_port_cmd (.*);
	pse_host_model i_pse_host_model (.*);

	initial
	begin
		clk_sys = 1'h0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		seenDet |= probeDetectReq;
		seenCls |= probeClassReq;
		nDet += detectDoneEvt[0];
		nCls += classDoneEvt[0];
	end

	// ====================
	// tasks
	task chk(input string n, input logic [31:0] e, s);
		n_compared++;
		if (s !== e)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task wr(input logic [7:0] a, d);
		i_pse_host_model.wr(a, d);
	endtask : wr

	task automatic wt(ref logic [3:0] v, input int n);
		for (int k = 0; k < n && v[0] !== 1'h1; k++)
			@(negedge clk_sys);
	endtask : wt

	task vp(input logic d, c, f, input logic [3:0] r);
		@(negedge clk_sys);
		detectValid[0] = d;
		classValid[0] = c;
		probeFault[0] = f;
		detectResult[3:0] = r;
		classResult[3:0] = r;
		@(negedge clk_sys);
		{detectValid, classValid, probeFault} = '0;
	endtask : vp

	task pe(input logic [7:0] v);
		@(negedge clk_sys);
		probeEnableIn = v;
		probeEnableLoad = 1'h1;
		@(negedge clk_sys);
		probeEnableLoad = 1'h0;
	endtask : pe

	task up(input logic f);
		seenDet = '0;
		seenCls = '0;
		probeBusy[0] = 1'h1;
		wr(8'h19, 8'h01);
		repeat (4) @(negedge clk_sys);
		chk("busy wait", 4'h0, seenDet);
		probeBusy[0] = 1'h0;
		wt(seenDet, 20);
		vp(!f, 1'h0, f, 4'h4);
		if (!f)
		begin
			wt(seenCls, 20);
			vp(1'h0, 1'h1, 1'h0, 4'h2);
		end
	endtask : up

	task close_out();
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	// ====================
	// tests
	initial
	begin
		{alertRequest, alert_pin_n_in, probeEnableLoad, emergency_off_evt,
			probeEnableIn, probeBusy, detectValid, classValid, probeFault,
			portReinit, drainLow, autoAutoclass, autoclassCapable,
			autoclassValid, budgetWrEn, keep_power_on_overbudget, seenDet,
			current_limit_evt, disconnectEvt, seenCls, detectResult,
			classResult, host_budget, autoclassPower, budgetWrData,
			measuredPower, portMode, n_fail, n_compared, nDet, nCls} = '0;
		granted_tier = 16'h0002;
		alertRequest = 1'h1;
		rst_b = 1'h0;
		repeat (10) @(negedge clk_sys);
		rst_b = 1'h1;
		portMode = 8'h55;
		chk("oe reset", 1'h0, alert_pin_n_oe);
		chk("pin level", 1'h0, alert_pin_n_out);
		i_pse_host_model.rd(8'h17, rdv);
		chk("global reset", 8'h80, rdv);
		i_pse_host_model.rd(8'h18, rdv);
		chk("probe read", 8'h00, rdv);
		i_pse_host_model.rd(8'h2c, rdv);
		chk("unmapped", 8'h00, rdv);
		wr(8'h17, 8'h00);
		chk("oe on", 1'h1, alert_pin_n_oe);
		wr(8'h17, 8'hff);
		i_pse_host_model.rd(8'h17, rdv);
		chk("global mask", 8'h9e, rdv);
		chk("priority", 1'h1, multiBitPriority);
		chk("midspan", 1'h1, midspan);
		chk("oe off", 1'h0, alert_pin_n_oe);
		wr(8'h17, 8'h00);
		vp(1'h1, 1'h1, 1'h0, 4'h4);
		vp(1'h1, 1'h1, 1'h0, 4'h4);
		wr(8'h17, 8'h0c);
		vp(1'h1, 1'h1, 1'h0, 4'h4);
		vp(1'h1, 1'h1, 1'h0, 4'h5);
		@(negedge clk_sys);
		chk("detect done", 3, nDet);
		chk("class done", 3, nCls);
		chk("detect status", 4'h5, detectStatus[3:0]);
		chk("class status", 4'h5, classStatus[3:0]);
		for (int i = 0; i < 4; i++)
		begin
			seenDet = '0;
			seenCls = '0;
			wr(8'h18, {{4{i[1]}}, {4{i[0]}}});
			chk("detect req", i[0] ? 4'hf : 4'h0, seenDet);
			chk("class req", i == 3 ? 4'hf : 4'h0, seenCls);
		end
		portMode = 8'haa;
		seenDet = '0;
		wr(8'h18, 8'h5a);
		chk("enable copy", 8'h5a, probeEnable);
		chk("no request", 4'h0, seenDet);
		portMode = 8'h55;
		pe(8'h11);
		drainLow[0] = 1'h1;
		up(1'h0);
		wt(fetOn, 20);
		chk("fet on", 1'h1, fetOn[0]);
		chk("supply on", 1'h1, supplyOn[0]);
		chk("early good", 1'h0, powerGood[0]);
		@(negedge clk_sys);
		chk("tier budget", 8'h50, budget_limit[7:0]);
		wt(powerGood, 20);
		chk("power good", 1'h1, powerGood[0]);
		budgetWrData[7:0] = 8'h40;
		budgetWrEn[0] = 1'h1;
		@(negedge clk_sys);
		budgetWrEn[0] = 1'h0;
		@(negedge clk_sys);
		chk("host budget", 8'h40, budget_limit[7:0]);
		autoAutoclass[0] = 1'h1;
		autoclassCapable[0] = 1'h1;
		autoclassPower[7:0] = 8'h44;
		autoclassValid[0] = 1'h1;
		@(negedge clk_sys);
		autoclassValid[0] = 1'h0;
		chk("autoclass budget", 8'h44, budget_limit[7:0]);
		keep_power_on_overbudget[0] = 1'h1;
		measuredPower[7:0] = 8'h48;
		wt(overbudget_evt, 5);
		chk("overbudget", 1'h1, overbudget_evt[0]);
		repeat (3) @(negedge clk_sys);
		chk("kept on", 1'h1, fetOn[0]);
		emergency_off_evt = 1'h1;
		@(negedge clk_sys);
		emergency_off_evt = 1'h0;
		@(negedge clk_sys);
		chk("emergency fet", 1'h0, fetOn[0]);
		chk("emergency budget", 8'h00, budget_limit[7:0]);
		measuredPower = '0;
		drainLow[0] = 1'h0;
		up(1'h0);
		wt(inrushFaultEvt, 30);
		chk("inrush fault", 1'h1, inrushFaultEvt[0]);
		chk("inrush fet", 1'h0, fetOn[0]);
		up(1'h1);
		wt(preFaultEvt, 5);
		chk("pre fault", 1'h1, preFaultEvt[0]);
		pe(8'h00);
		drainLow[0] = 1'h1;
		host_budget[7:0] = 8'h33;
		wr(8'h19, 8'h01);
		@(negedge clk_sys);
		chk("skip fet", 1'h1, fetOn[0]);
		repeat (2) @(negedge clk_sys);
		chk("skip budget", 8'h33, budget_limit[7:0]);
		wr(8'h19, 8'h10);
		@(negedge clk_sys);
		chk("off fet", 1'h0, fetOn[0]);
		chk("off budget", 8'h00, budget_limit[7:0]);
		wr(8'h19, 8'h11);
		repeat (3) @(negedge clk_sys);
		chk("off wins", 1'h0, fetOn[0]);
		wr(8'h19, 8'h01);
		chk("reinit on", 1'h1, fetOn[0]);
		portReinit[0] = 1'h1;
		@(negedge clk_sys);
		portReinit[0] = 1'h0;
		chk("reinit fet", 1'h0, fetOn[0]);
		wr(8'h19, 8'h01);
		portMode = 8'h54;
		@(negedge clk_sys);
		chk("shutdown fet", 1'h0, fetOn[0]);
		close_out();
	end

	initial
	begin
		#1000000;
		n_fail++;
		close_out();
	end
endmodule : pse_port_command_control_bench
